//--- sensor_regs_pkg.sv
package sensor_regs_pkg;

  // ----------------------------------------
  // register pointers
  // ----------------------------------------
  localparam logic [3:0] PTR_TEMP = 4'h0;
  localparam logic [3:0] PTR_CTRL = 4'h1;
  localparam logic [3:0] PTR_UPPER_A = 4'h2;
  localparam logic [3:0] PTR_LOWER_A = 4'h3;
  localparam logic [3:0] PTR_UPPER_B = 4'h4;
  localparam logic [3:0] PTR_LOWER_B = 4'h5;
  localparam logic [3:0] PTR_STORE_FIRST = 4'h6;
  localparam logic [3:0] PTR_STORE_LAST = 4'hd;
  localparam logic [3:0] PTR_UNUSED = 4'he;
  localparam logic [3:0] PTR_IDENT = 4'hf;
  localparam logic [3:0] PTR_NV_FIRST = 4'h1;
  localparam logic [3:0] PTR_NV_LAST = 4'hd;

  // ----------------------------------------
  // temperature_result fields
  // ----------------------------------------
  localparam int TEMP_MSB = 15;
  localparam int TEMP_LSB = 2;
  localparam int TEMP_BUSY_BIT = 1;
  localparam int TEMP_UNLOCK_BIT = 0;
  localparam int TEMP_WIDTH = 14;

  // ----------------------------------------
  // operation_control fields
  // ----------------------------------------
  localparam int CTRL_RATE_MSB = 15;
  localparam int CTRL_RATE_LSB = 13;
  localparam int CTRL_ONE_SHOT_BIT = 12;
  localparam int CTRL_POWER_DOWN_BIT = 11;
  localparam int CTRL_UPPER_FLAG_A_BIT = 10;
  localparam int CTRL_LOWER_FLAG_A_BIT = 9;
  localparam int CTRL_MODE_A_BIT = 8;
  localparam int CTRL_POL_A_BIT = 7;
  localparam int CTRL_UPPER_FLAG_B_BIT = 6;
  localparam int CTRL_LOWER_FLAG_B_BIT = 5;
  localparam int CTRL_MODE_B_BIT = 4;
  localparam int CTRL_POL_B_BIT = 3;
  localparam int CTRL_SOFT_RESET_BIT = 1;
  // bits that store a value: rate, power down, modes, polarities
  localparam logic [15:0] CTRL_STORE_MASK = 16'he998;
  localparam logic [15:0] CTRL_RESET = 16'ha000;

  // ----------------------------------------
  // factory defaults of the other stored words
  // ----------------------------------------
  localparam logic [15:0] UPPER_A_DEFAULT = 16'h0000;
  localparam logic [15:0] LOWER_A_DEFAULT = 16'h0000;
  localparam logic [15:0] UPPER_B_DEFAULT = 16'h0000;
  localparam logic [15:0] LOWER_B_DEFAULT = 16'h0000;
  localparam logic [15:0] STORE_DEFAULT = 16'h0000;
  // arbitrary neutral identity value
  localparam logic [15:0] IDENT_DEFAULT = 16'h5a5a;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int NV_READ_US = 100;
  localparam int PROG_MS = 16;
  localparam int NV_READ_CYCLES = NV_READ_US * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_MS * 1000 * CLK_MHZ;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] ptr;
    logic [15:0] wdata;
  } access_req_t;

  typedef struct packed {
    logic done;
    logic [13:0] result;
    logic upper_a;
    logic lower_a;
    logic upper_b;
    logic lower_b;
  } conv_in_t;

  typedef struct packed {
    logic [2:0] rate;
    logic power_down;
    logic mode_a;
    logic pol_a;
    logic mode_b;
    logic pol_b;
  } conv_ctrl_t;

endpackage : sensor_regs_pkg

//--- nv_store.sv
`timescale 1ns/1ps
module nv_store #(
  parameter int PROG_CYCLES = sensor_regs_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic factory_init,
  input wire logic [3:0] rd_idx,
  output logic [15:0] rd_word,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_word,
  output logic busy
);

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);

  // the array survives srst; only factory_init writes the defaults
  logic [15:0] mem [1:13];
  logic [CW-1:0] prog_cnt_r;

  // ----------------------------------------
  // storage array
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (factory_init) begin
      mem[1] <= sensor_regs_pkg::CTRL_RESET;
      mem[2] <= sensor_regs_pkg::UPPER_A_DEFAULT;
      mem[3] <= sensor_regs_pkg::LOWER_A_DEFAULT;
      mem[4] <= sensor_regs_pkg::UPPER_B_DEFAULT;
      mem[5] <= sensor_regs_pkg::LOWER_B_DEFAULT;
      for (int i = 6; i <= 13; i++) begin
        mem[i] <= sensor_regs_pkg::STORE_DEFAULT;
      end
    end else if (wr_en && !busy && wr_idx >= sensor_regs_pkg::PTR_NV_FIRST &&
                 wr_idx <= sensor_regs_pkg::PTR_NV_LAST) begin
      mem[wr_idx] <= wr_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rd_idx >= sensor_regs_pkg::PTR_NV_FIRST && rd_idx <= sensor_regs_pkg::PTR_NV_LAST) begin
      rd_word <= mem[rd_idx];
    end else begin
      rd_word <= 16'h0000;
    end
  end

  // ----------------------------------------
  // programming time
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      busy <= 1'b0;
      prog_cnt_r <= '0;
    end else if (wr_en && !busy) begin
      busy <= 1'b1;
      prog_cnt_r <= '0;
    end else if (busy) begin
      if (prog_cnt_r == PROG_LAST) begin
        busy <= 1'b0;
      end
      prog_cnt_r <= prog_cnt_r + CW'(1);
    end
  end

endmodule : nv_store

//--- sensor_register_file.sv
`timescale 1ns/1ps
module sensor_register_file #(
  parameter int NV_READ_CYCLES = sensor_regs_pkg::NV_READ_CYCLES,
  parameter int PROG_CYCLES = sensor_regs_pkg::PROG_CYCLES,
  parameter logic [15:0] IDENT = sensor_regs_pkg::IDENT_DEFAULT
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic factory_init,
  input wire sensor_regs_pkg::access_req_t req,
  output logic req_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  input wire sensor_regs_pkg::conv_in_t conv_in,
  output sensor_regs_pkg::conv_ctrl_t conv_ctrl,
  output logic conv_restart,
  output logic one_shot_start
);

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_RD_WAIT} state_t;

  localparam int RW = $clog2(NV_READ_CYCLES + 1);
  localparam logic [RW-1:0] RD_LAST = RW'(NV_READ_CYCLES - 1);

  function automatic logic is_nv(input logic [3:0] p);
    is_nv = (p >= sensor_regs_pkg::PTR_NV_FIRST) && (p <= sensor_regs_pkg::PTR_NV_LAST);
  endfunction : is_nv

  function automatic logic is_store(input logic [3:0] p);
    is_store = (p >= sensor_regs_pkg::PTR_STORE_FIRST) && (p <= sensor_regs_pkg::PTR_STORE_LAST);
  endfunction : is_store

  state_t state_r;
  logic [3:0] load_idx_r;
  logic [3:0] load_dst_r;
  logic load_cap_r;
  logic [15:0] vol_r [1:13];
  logic [13:0] temp_r;
  logic unlock_r;
  logic [3:0] flags_r;
  logic [RW-1:0] rd_cnt_r;
  logic [3:0] rd_ptr_r;
  logic soft_reset_r;
  logic [15:0] nv_word;
  logic nv_busy;
  logic take;
  logic wr_take;
  logic vol_we;
  logic nv_wr;
  logic ctrl_wr;
  logic [15:0] ctrl_word;
  logic reload;

  assign take = req.valid && req_ready;
  assign wr_take = take && req.write;
  assign reload = srst || soft_reset_r;
  assign ctrl_word = vol_r[1] & sensor_regs_pkg::CTRL_STORE_MASK;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // while programming runs every write except the unlock bit is dropped
  always_comb begin
    vol_we = 1'b0;
    nv_wr = 1'b0;
    if (wr_take && is_nv(req.ptr) && !nv_busy) begin
      if (unlock_r) begin
        nv_wr = 1'b1;
        vol_we = 1'b1;
      end else if (!is_store(req.ptr)) begin
        vol_we = 1'b1;
      end
    end
  end

  assign ctrl_wr = vol_we && (req.ptr == sensor_regs_pkg::PTR_CTRL);

  nv_store #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_nv (
    .clk(clk),
    .srst(srst),
    .factory_init(factory_init),
    .rd_idx(load_idx_r),
    .rd_word(nv_word),
    .wr_en(nv_wr),
    .wr_idx(req.ptr),
    .wr_word(req.ptr == sensor_regs_pkg::PTR_CTRL ?
             (req.wdata & sensor_regs_pkg::CTRL_STORE_MASK) : req.wdata),
    .busy(nv_busy)
  );

  // ----------------------------------------
  // sequencing: load after reset, read delay
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reload) begin
      state_r <= ST_LOAD;
      load_idx_r <= sensor_regs_pkg::PTR_NV_FIRST;
      load_cap_r <= 1'b0;
      req_ready <= 1'b0;
      rd_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_LOAD: begin
          load_cap_r <= is_nv(load_idx_r);
          load_dst_r <= load_idx_r;
          if (load_idx_r == sensor_regs_pkg::PTR_UNUSED) begin
            state_r <= ST_IDLE;
            req_ready <= 1'b1;
          end else begin
            load_idx_r <= load_idx_r + 4'h1;
          end
        end
        ST_IDLE: begin
          load_cap_r <= 1'b0;
          if (take && !req.write && is_nv(req.ptr)) begin
            state_r <= ST_RD_WAIT;
            req_ready <= 1'b0;
            rd_cnt_r <= '0;
          end
        end
        ST_RD_WAIT: begin
          rd_cnt_r <= rd_cnt_r + RW'(1);
          if (rd_cnt_r == RD_LAST) begin
            state_r <= ST_IDLE;
            req_ready <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_LOAD;
          req_ready <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // stored registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (load_cap_r && !srst) begin
      vol_r[load_dst_r] <= nv_word;
    end else if (vol_we) begin
      vol_r[req.ptr] <= req.wdata;
    end
  end

  // ----------------------------------------
  // temperature and status
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reload) begin
      temp_r <= '0;
    end else if (conv_in.done) begin
      temp_r <= conv_in.result;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unlock_r <= 1'b0;
    end else if (wr_take && req.ptr == sensor_regs_pkg::PTR_TEMP) begin
      unlock_r <= req.wdata[sensor_regs_pkg::TEMP_UNLOCK_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reload) begin
      flags_r <= '0;
    end else if (conv_in.done) begin
      flags_r <= {conv_in.upper_a, conv_in.lower_a, conv_in.upper_b, conv_in.lower_b};
    end
  end

  // ----------------------------------------
  // control effects
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reload) begin
      soft_reset_r <= 1'b0;
      conv_restart <= 1'b0;
      one_shot_start <= 1'b0;
    end else begin
      soft_reset_r <= ctrl_wr && req.wdata[sensor_regs_pkg::CTRL_SOFT_RESET_BIT];
      conv_restart <= ctrl_wr;
      one_shot_start <= ctrl_wr && req.wdata[sensor_regs_pkg::CTRL_ONE_SHOT_BIT] &&
                        req.wdata[sensor_regs_pkg::CTRL_POWER_DOWN_BIT];
    end
  end

  // conv_ctrl follows the stored word; until the load ends it shows the reset value
  always_ff @(posedge clk) begin
    if (reload) begin
      conv_ctrl <= '{rate: sensor_regs_pkg::CTRL_RESET[15:13], default: 1'b0};
    end else if (state_r != ST_LOAD) begin
      conv_ctrl.rate <= ctrl_word[sensor_regs_pkg::CTRL_RATE_MSB:sensor_regs_pkg::CTRL_RATE_LSB];
      conv_ctrl.power_down <= ctrl_word[sensor_regs_pkg::CTRL_POWER_DOWN_BIT];
      conv_ctrl.mode_a <= ctrl_word[sensor_regs_pkg::CTRL_MODE_A_BIT];
      conv_ctrl.pol_a <= ctrl_word[sensor_regs_pkg::CTRL_POL_A_BIT];
      conv_ctrl.mode_b <= ctrl_word[sensor_regs_pkg::CTRL_MODE_B_BIT];
      conv_ctrl.pol_b <= ctrl_word[sensor_regs_pkg::CTRL_POL_B_BIT];
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reload) begin
      rd_valid <= 1'b0;
      rd_data <= '0;
      rd_ptr_r <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (take && !req.write) begin
        rd_ptr_r <= req.ptr;
        if (!is_nv(req.ptr)) begin
          rd_valid <= 1'b1;
          case (req.ptr)
            sensor_regs_pkg::PTR_TEMP: rd_data <= {temp_r, nv_busy, unlock_r};
            sensor_regs_pkg::PTR_IDENT: rd_data <= IDENT;
            default: rd_data <= 16'h0000;
          endcase
        end
      end else if (state_r == ST_RD_WAIT && rd_cnt_r == RD_LAST) begin
        rd_valid <= 1'b1;
        // storage reads ignore the lock state
        if (rd_ptr_r == sensor_regs_pkg::PTR_CTRL) begin
          rd_data <= ctrl_word | {5'h00, flags_r[3:2], 2'h0, flags_r[1:0], 5'h00};
        end else begin
          rd_data <= vol_r[rd_ptr_r];
        end
      end
    end
  end

  // pointer e and identity writes fall through every decode above: no state changes

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_reset_release;
    srst ##1 !srst;
  endsequence

  sequence s_nv_read;
    take && !req.write && is_nv(req.ptr);
  endsequence

  property p_reload_holds_off;
    @(posedge clk) s_reset_release |-> !req_ready [*8];
  endproperty
  a_reload_holds_off: assert property (p_reload_holds_off) else $error("requests taken during load");

  property p_temp_zero;
    @(posedge clk) srst |=> (temp_r == 14'h0000) && !unlock_r;
  endproperty
  a_temp_zero: assert property (p_temp_zero) else $error("reset left temp or unlock set");

  property p_locked_no_program;
    @(posedge clk) disable iff (srst) (wr_take && !unlock_r) |-> !nv_wr;
  endproperty
  a_locked_no_program: assert property (p_locked_no_program) else $error("program while locked");

  property p_busy_blocks;
    @(posedge clk) disable iff (srst) (wr_take && nv_busy) |-> !vol_we && !nv_wr;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("write passed while busy");

  property p_ctrl_restart;
    @(posedge clk) disable iff (srst)
      (wr_take && req.ptr == sensor_regs_pkg::PTR_CTRL && !nv_busy) |=> conv_restart;
  endproperty
  a_ctrl_restart: assert property (p_ctrl_restart) else $error("no restart on control write");

  property p_one_shot_reads_zero;
    @(posedge clk) disable iff (srst)
      (rd_valid && rd_ptr_r == sensor_regs_pkg::PTR_CTRL) |->
      !rd_data[sensor_regs_pkg::CTRL_ONE_SHOT_BIT] && !rd_data[sensor_regs_pkg::CTRL_SOFT_RESET_BIT];
  endproperty
  a_one_shot_reads_zero: assert property (p_one_shot_reads_zero) else $error("one-shot read 1");

  property p_nv_read_delay;
    @(posedge clk) disable iff (srst) s_nv_read |=> !rd_valid [*8];
  endproperty
  a_nv_read_delay: assert property (p_nv_read_delay) else $error("stored read answered early");

  property p_ident_read;
    @(posedge clk) disable iff (srst)
      (take && !req.write && req.ptr == sensor_regs_pkg::PTR_IDENT) |=> rd_valid && rd_data == IDENT;
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("identity read wrong");

  property p_prog_busy;
    @(posedge clk) disable iff (srst) nv_wr |=> nv_busy [*8];
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("busy dropped during programming");

endmodule : sensor_register_file

//--- sensor_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side of the register access port
// ----------------------------------------
module sensor_host_model (
  input wire logic clk,
  output sensor_regs_pkg::access_req_t req,
  input wire logic req_ready,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data
);
  logic hung;

  initial begin
    req = '0;
    hung = 1'b0;
  end

  // whole words only, so a result is never split across two reads
  task automatic xfer(input logic wr, input logic [3:0] ptr, input logic [15:0] d,
                      output logic [15:0] q, output int lat);
    logic rdy;
    q = 16'h0000;
    lat = 0;
    rdy = 1'b0;
    @(posedge clk);
    #1;
    req.valid = 1'b1;
    req.write = wr;
    req.ptr = ptr;
    req.wdata = d;
    for (int n = 0; n < 300 && !rdy; n++) begin
      @(negedge clk);
      rdy = req_ready;
      @(posedge clk);
    end
    #1;
    // released ptr and wdata lines show the inverse, never the stale request
    req.valid = 1'b0;
    req.ptr = ~ptr;
    req.wdata = ~d;
    if (!rdy) begin
      hung = 1'b1;
    end else if (!wr) begin
      // a long gap before the answer of a stored register is tolerated
      // a fast answer already stands at the first falling edge after the take
      for (lat = 1; lat < 300; lat++) begin
        @(negedge clk);
        if (rd_valid) begin
          break;
        end
        @(posedge clk);
      end
      q = rd_data;
      if (lat >= 300) begin
        hung = 1'b1;
      end
    end
  endtask : xfer
endmodule : sensor_host_model

//--- sensor_register_file_tb_top.sv
`timescale 1ns/1ps
module sensor_register_file_tb_top;
  localparam int NVR = 16;
  localparam int PRG = 32;
  // arbitrary identity value
  localparam logic [15:0] ID_VAL = 16'h3c96;
  logic clk;
  logic srst;
  logic factory_init;
  sensor_regs_pkg::access_req_t req;
  logic req_ready;
  logic rd_valid;
  logic [15:0] rd_data;
  sensor_regs_pkg::conv_in_t conv_in;
  sensor_regs_pkg::conv_ctrl_t conv_ctrl;
  logic conv_restart;
  logic one_shot_start;
  int bad_count;
  int cmp_count;
  int cyc;
  int seed;
  int lat;
  int t0;
  logic [15:0] q, w, d6, wc;
  logic [13:0] t;
  logic [3:0] fl;

  sensor_register_file #(.NV_READ_CYCLES(NVR), .PROG_CYCLES(PRG), .IDENT(ID_VAL)) i_sensor_register_file (
    .clk(clk), .srst(srst), .factory_init(factory_init), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .conv_in(conv_in), .conv_ctrl(conv_ctrl),
    .conv_restart(conv_restart), .one_shot_start(one_shot_start));

  sensor_host_model i_sensor_host_model (
    .clk(clk), .req(req), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    clk = 1'b0;
    cyc = 0;
  end
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic access(input logic wr, input logic [3:0] p, input logic [15:0] d);
    i_sensor_host_model.xfer(wr, p, d, q, lat);
    if (i_sensor_host_model.hung) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : access

  task automatic rd_chk(input string name, input logic [3:0] p, input logic [15:0] exp);
    logic nv;
    nv = (p >= sensor_regs_pkg::PTR_NV_FIRST) && (p <= sensor_regs_pkg::PTR_NV_LAST);
    access(1'b0, p, 16'($urandom()));
    check(name, q, exp);
    check({name, "_lat"}, 16'(lat), nv ? 16'(NVR + 1) : 16'h0001);
  endtask : rd_chk

  function automatic logic [15:0] ctrl_exp(input logic [15:0] v, input logic [3:0] f);
    return (v & sensor_regs_pkg::CTRL_STORE_MASK) | {5'h0, f[3:2], 2'h0, f[1:0], 5'h0};
  endfunction : ctrl_exp

  function automatic logic [15:0] fields_exp(input logic [15:0] v);
    return {8'h0, v[15:13], v[11], v[8], v[7], v[4], v[3]};
  endfunction : fields_exp

  task automatic do_reset();
    @(posedge clk);
    #1;
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    srst = 1'b0;
  endtask : do_reset

  // poll until programming ends; the span proves busy covered all of it
  task automatic wait_idle();
    q = 16'h0002;
    for (int n = 0; n < PRG + 40 && q[1]; n++) begin
      access(1'b0, sensor_regs_pkg::PTR_TEMP, 16'h0000);
    end
    check("busy_clear", {15'h0, q[1]}, 16'h0000);
    check("busy_span", 16'((cyc - t0 >= PRG) && (cyc - t0 <= PRG + 10)), 16'h0001);
  endtask : wait_idle

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    bad_count = 0;
    cmp_count = 0;
    srst = 1'b1;
    factory_init = 1'b1;
    conv_in = '0;
    seed = $urandom(9731);
    @(posedge clk);
    #1;
    factory_init = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    rd_chk("temp_rst", sensor_regs_pkg::PTR_TEMP, 16'h0000);
    rd_chk("ctrl_rst", sensor_regs_pkg::PTR_CTRL, 16'ha000);
    check("fields_rst", {8'h0, conv_ctrl}, fields_exp(16'ha000));
    for (int p = 6; p <= 13; p++) begin
      access(1'b1, 4'(p), 16'($urandom()));
      rd_chk("store_locked", 4'(p), 16'h0000);
    end
    for (int p = 2; p <= 5; p++) begin
      w = 16'($urandom());
      access(1'b1, 4'(p), w);
      rd_chk("limit_locked", 4'(p), w);
    end
    access(1'b1, sensor_regs_pkg::PTR_UNUSED, 16'($urandom()));
    access(1'b1, sensor_regs_pkg::PTR_IDENT, 16'($urandom()));
    rd_chk("unused", sensor_regs_pkg::PTR_UNUSED, 16'h0000);
    rd_chk("ident", sensor_regs_pkg::PTR_IDENT, ID_VAL);
    for (int k = 0; k < 8; k++) begin
      w = {3'(k), 13'($urandom())} & ~16'h0002;
      if (k == 6) begin
        w[12:11] = 2'b11;
      end else if (k == 7) begin
        w[12:11] = 2'b10;
      end
      access(1'b1, sensor_regs_pkg::PTR_CTRL, w);
      check("restart", {15'h0, conv_restart}, 16'h0001);
      check("one_shot", {15'h0, one_shot_start}, {15'h0, w[12] & w[11]});
      @(posedge clk);
      #1;
      check("fields", {8'h0, conv_ctrl}, fields_exp(w));
      check("restart_end", {15'h0, conv_restart}, 16'h0000);
      rd_chk("ctrl_rb", sensor_regs_pkg::PTR_CTRL, ctrl_exp(w, 4'h0));
    end
    for (int j = 0; j < 2; j++) begin
      t = (j == 0) ? 14'h2000 : 14'($urandom());
      fl = 4'($urandom());
      @(posedge clk);
      #1;
      conv_in = {1'b1, t, fl};
      @(posedge clk);
      #1;
      conv_in.done = 1'b0;
      rd_chk("temp_val", sensor_regs_pkg::PTR_TEMP, {t, 2'b00});
      rd_chk("flags", sensor_regs_pkg::PTR_CTRL, ctrl_exp(w, fl));
    end
    access(1'b1, sensor_regs_pkg::PTR_TEMP, {14'($urandom()), 2'b00});
    rd_chk("temp_ro", sensor_regs_pkg::PTR_TEMP, {t, 2'b00});
    access(1'b1, sensor_regs_pkg::PTR_CTRL, 16'h0002);
    rd_chk("temp_soft", sensor_regs_pkg::PTR_TEMP, 16'h0000);
    rd_chk("limit_soft", sensor_regs_pkg::PTR_UPPER_A, 16'h0000);
    rd_chk("ctrl_soft", sensor_regs_pkg::PTR_CTRL, 16'ha000);
    access(1'b1, sensor_regs_pkg::PTR_TEMP, 16'h0001);
    rd_chk("unlock", sensor_regs_pkg::PTR_TEMP, 16'h0001);
    d6 = 16'($urandom());
    access(1'b1, sensor_regs_pkg::PTR_STORE_FIRST, d6);
    t0 = cyc;
    rd_chk("busy_set", sensor_regs_pkg::PTR_TEMP, 16'h0003);
    access(1'b1, 4'h7, 16'($urandom()));
    access(1'b1, sensor_regs_pkg::PTR_UPPER_A, 16'($urandom()));
    wait_idle();
    rd_chk("blocked_st", 4'h7, 16'h0000);
    rd_chk("blocked_lim", sensor_regs_pkg::PTR_UPPER_A, 16'h0000);
    rd_chk("programmed", sensor_regs_pkg::PTR_STORE_FIRST, d6);
    wc = 16'($urandom()) & sensor_regs_pkg::CTRL_STORE_MASK;
    access(1'b1, sensor_regs_pkg::PTR_CTRL, wc);
    t0 = cyc;
    rd_chk("ctrl_busy", sensor_regs_pkg::PTR_TEMP, 16'h0003);
    wait_idle();
    access(1'b1, sensor_regs_pkg::PTR_TEMP, 16'h0000);
    do_reset();
    rd_chk("st_reload", sensor_regs_pkg::PTR_STORE_FIRST, d6);
    rd_chk("ctrl_reload", sensor_regs_pkg::PTR_CTRL, wc);
    rd_chk("temp_relock", sensor_regs_pkg::PTR_TEMP, 16'h0000);
    check("fields_rl", {8'h0, conv_ctrl}, fields_exp(wc));
    tally_and_finish();
  end
endmodule : sensor_register_file_tb_top
